// >>> hdl/ipc_pkg.sv
// Package: register map, field positions and timing for the packet composer config
package ipc_pkg;
  // Byte offsets within the composer window (printed offsets are byte indexes)
  localparam logic [15:0] CH2_FILLER_IDX = 16'h1016;
  localparam logic [15:0] VID_CFG3_IDX = 16'h1017;
  localparam logic [15:0] GCP_CFG_IDX = 16'h1018;
  localparam logic [15:0] VID_CFG0_IDX = 16'h1019;
  localparam logic [15:0] VID_CFG1_IDX = 16'h101a;
  localparam logic [15:0] VID_CFG2_IDX = 16'h101b;
  localparam logic [15:0] VID_CODE_IDX = 16'h101c;
  localparam logic [15:0] TOP_BAR_IDX = 16'h101d;
  localparam logic [15:0] BOT_BAR_IDX = 16'h101f;
  localparam logic [15:0] LEFT_BAR_IDX = 16'h1021;
  localparam logic [15:0] RIGHT_BAR_IDX = 16'h1023;
  localparam logic [15:0] AUD_CFG0_IDX = 16'h1025;
  localparam logic [15:0] AUD_CFG1_IDX = 16'h1026;
  localparam logic [15:0] AUD_CFG2_IDX = 16'h1027;
  localparam logic [15:0] AUD_CFG3_IDX = 16'h1028;
  localparam logic [15:0] REGID2_IDX = 16'h1029;
  localparam logic [15:0] VLEN_IDX = 16'h102a;
  localparam logic [15:0] REGID1_IDX = 16'h102b;
  localparam logic [15:0] REGID0_IDX = 16'h1031;
  localparam logic [15:0] VPAY_IDX = 16'h1032;
  localparam logic [15:0] SPD_VEND_IDX = 16'h104a;
  localparam logic [15:0] SPD_NAME_IDX = 16'h1052;
  localparam logic [15:0] SPD_INFO_IDX = 16'h1062;
  localparam logic [15:0] AUDS_CFG_IDX = 16'h1063;
  localparam logic [15:0] AUDS_STAT_IDX = 16'h1064;
  localparam logic [15:0] FIRST_IDX = 16'h1016;
  // Window runs from the channel 2 filler up to and including the status byte
  localparam int NUM_BYTES = 79;
  localparam int VPAY_LEN = 24;
  localparam int SPD_VEND_LEN = 8;
  localparam int SPD_NAME_LEN = 16;
  localparam logic [7:0] VLEN_RESET = 8'h1b;
  // GCP field positions and the audio sample layout bit
  localparam int GCP_CLEAR_BIT = 0;
  localparam int GCP_SET_BIT = 1;
  localparam int GCP_PHASE_BIT = 2;
  localparam int AUDS_LAYOUT_BIT = 0;
  // Mute window after vsync, in pixels
  localparam int MUTE_WINDOW_PIX = 384;
endpackage : ipc_pkg

// >>> hdl/ipc_composer_cfg.sv
// Packet composer configuration registers, mute scheduler and packet field outputs
//
// Function
// - A written mute request queues exactly one mute control packet.
// - Mute packet is sent only within 384 pixels after vsync active edge.
// - Clear-mute flag comes from control packet config bit 0.
// - Control periods drive the 6-bit filler onto channel 2 spare lines.
// - Video frame byte 0 fields: Y2, format present, scan, bars, Y1..Y0.
// - Video byte 1: colorimetry, picture aspect, active aspect.
// - Video byte 2: IT flag, extended colorimetry, quantization, scaling.
// - Video byte 3: YCC quantization and It_flag kind, top bits reserved.
// - Video format id is seven bits plus a separate eighth bit.
// - Four bar values are two-byte arrays placed in the video frame.
// - Audio frame: channel total, coding type and speaker placement code.
// - Audio frame: sample size and sample rate code from byte 1.
// - Audio frame: low-frequency level, downmix inhibit and level shift.
// - Vendor frame registration id assembled from three byte registers.
// - Vendor frame length is a five-bit field resetting to 0x1b.
// - Vendor frame payload is 24 bytes starting at 0x1032.
// - Product descriptor vendor name is 8 bytes from 0x104a.
// - Product descriptor product name is 16 bytes from 0x1052.
// - Sample-flat nibble goes into sent audio sample packets.
// - Layout bit selects layout 1 or 0, ignored in multistream mode.
// - Read-only status shows sample-present flags of the last sample packet.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module ipc_composer_cfg #(
  parameter int PIX_CNT_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link side
  input wire logic vsync_edge,
  input wire logic pixel_en,
  input wire logic ctrl_period,
  input wire logic multistream_audio_enable,
  input wire logic aud_pkt_sent,
  input wire logic [3:0] aud_pkt_present,
  input wire logic pkt_assemble,
  input wire logic gcp_sent,
  output logic gcp_mute_req,
  output logic gcp_mute_flag,
  output logic gcp_clear_flag,
  output logic gcp_default_phase,
  output logic [5:0] chan2_filler_bits,
  output logic [3:0] aud_sample_flat,
  output logic aud_layout,
  output logic [8*13-1:0] video_frame_body,
  output logic [8*5-1:0] audio_frame_body,
  output logic [23:0] vendor_regid,
  output logic [4:0] vendor_len,
  output logic [8*24-1:0] vendor_payload,
  output logic [8*25-1:0] spd_body
);

  // ==========================================================
  // Register storage
  logic [7:0] regs [ipc_pkg::NUM_BYTES];
  logic [3:0] present_status;
  wire [15:0] byte_idx = paddr[17:2];
  wire in_range = (byte_idx >= ipc_pkg::FIRST_IDX) &&
                  (byte_idx < ipc_pkg::FIRST_IDX + 16'(ipc_pkg::NUM_BYTES));
  wire [6:0] slot = 7'(byte_idx - ipc_pkg::FIRST_IDX);
  wire is_status = (byte_idx == ipc_pkg::AUDS_STAT_IDX);
  wire access = psel && penable;
  wire wr_en = access && pwrite && in_range && !is_status;
  wire [7:0] rd_byte = is_status ? {4'h0, present_status} : (in_range ? regs[slot] : 8'h00);

  function automatic logic [7:0] rst_val(input int i);
    rst_val = (16'(i) + ipc_pkg::FIRST_IDX == ipc_pkg::VLEN_IDX) ? ipc_pkg::VLEN_RESET : 8'h00;
  endfunction : rst_val

  // Reserved bits are masked so they always read zero
  function automatic logic [7:0] wmask(input int i);
    logic [15:0] a;
    a = 16'(i) + ipc_pkg::FIRST_IDX;
    case (a)
      ipc_pkg::CH2_FILLER_IDX: wmask = 8'h3f;
      ipc_pkg::VID_CFG3_IDX: wmask = 8'h0f;
      ipc_pkg::GCP_CFG_IDX: wmask = 8'h07;
      ipc_pkg::AUD_CFG0_IDX: wmask = 8'h7f;
      ipc_pkg::AUD_CFG1_IDX: wmask = 8'h37;
      ipc_pkg::AUD_CFG3_IDX: wmask = 8'h7f;
      ipc_pkg::VLEN_IDX: wmask = 8'h1f;
      ipc_pkg::AUDS_CFG_IDX: wmask = 8'hf1;
      ipc_pkg::AUDS_STAT_IDX: wmask = 8'h00;
      // Gap between the registration id bytes holds no register and reads zero
      default: wmask = (a > ipc_pkg::REGID1_IDX && a < ipc_pkg::REGID0_IDX) ? 8'h00 : 8'hff;
    endcase
  endfunction : wmask

  genvar g;
  generate
    for (g = 0; g < ipc_pkg::NUM_BYTES; g++) begin : g_reg
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          regs[g] <= rst_val(g);
        end else if (wr_en && slot == 7'(g)) begin
          regs[g] <= pwdata[7:0] & wmask(g);
        end
      end
    end
  endgenerate

  function automatic logic [7:0] rb(input logic [15:0] idx);
    rb = regs[7'(idx - ipc_pkg::FIRST_IDX)];
  endfunction : rb

  // ==========================================================
  // APB answer: zero wait states, unmapped reads zero without error
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h0, rd_byte};
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // Mute scheduling
  typedef enum logic [1:0] {IPC_IDLE, IPC_WAIT_VS, IPC_WINDOW} ipc_mute_e;
  ipc_mute_e state, next_state;
  logic [PIX_CNT_W-1:0] pix_cnt;
  logic set_prev;
  wire [7:0] gcp_reg = rb(ipc_pkg::GCP_CFG_IDX);
  wire set_rise = gcp_reg[ipc_pkg::GCP_SET_BIT] && !set_prev;
  wire win_open = (state == IPC_WINDOW) &&
                  (pix_cnt < PIX_CNT_W'(ipc_pkg::MUTE_WINDOW_PIX));
  wire next_req = (state == IPC_WINDOW) && win_open && !gcp_sent;

  always_comb begin
    next_state = state;
    case (state)
      IPC_IDLE: if (set_rise) next_state = IPC_WAIT_VS;
      IPC_WAIT_VS: if (vsync_edge) next_state = IPC_WINDOW;
      IPC_WINDOW: begin
        if (gcp_sent) next_state = IPC_IDLE;
        else if (!win_open) next_state = IPC_WAIT_VS;
      end
      default: next_state = IPC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IPC_IDLE;
      set_prev <= 1'b0;
      pix_cnt <= '0;
      gcp_mute_req <= 1'b0;
    end else begin
      state <= next_state;
      set_prev <= gcp_reg[ipc_pkg::GCP_SET_BIT];
      if (vsync_edge) pix_cnt <= '0;
      else if (pixel_en && win_open) pix_cnt <= pix_cnt + 1'b1;
      gcp_mute_req <= next_req && (next_state == IPC_WINDOW);
    end
  end

  // ==========================================================
  // Packet contents, latched at assembly time; the channel 2 filler follows ctrl_period every cycle
  logic [3:0] flat_q;
  // Named copies so single fields can be selected without slicing a call
  wire [7:0] filler_reg = rb(ipc_pkg::CH2_FILLER_IDX);
  wire [7:0] vlen_reg = rb(ipc_pkg::VLEN_IDX);
  wire [7:0] auds_reg = rb(ipc_pkg::AUDS_CFG_IDX);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gcp_mute_flag <= 1'b0;
      gcp_clear_flag <= 1'b0;
      gcp_default_phase <= 1'b0;
      chan2_filler_bits <= 6'h0;
      aud_sample_flat <= 4'h0;
      aud_layout <= 1'b0;
      video_frame_body <= '0;
      audio_frame_body <= '0;
      vendor_regid <= 24'h0;
      vendor_len <= 5'h0;
      vendor_payload <= '0;
      spd_body <= '0;
    end else begin
      chan2_filler_bits <= ctrl_period ? filler_reg[5:0] : 6'h0;
      if (pkt_assemble) begin
        gcp_mute_flag <= gcp_reg[ipc_pkg::GCP_SET_BIT];
        gcp_clear_flag <= gcp_reg[ipc_pkg::GCP_CLEAR_BIT];
        gcp_default_phase <= gcp_reg[ipc_pkg::GCP_PHASE_BIT];
        video_frame_body <= {rb(ipc_pkg::RIGHT_BAR_IDX + 16'h1), rb(ipc_pkg::RIGHT_BAR_IDX),
                             rb(ipc_pkg::LEFT_BAR_IDX + 16'h1), rb(ipc_pkg::LEFT_BAR_IDX),
                             rb(ipc_pkg::BOT_BAR_IDX + 16'h1), rb(ipc_pkg::BOT_BAR_IDX),
                             rb(ipc_pkg::TOP_BAR_IDX + 16'h1), rb(ipc_pkg::TOP_BAR_IDX),
                             rb(ipc_pkg::VID_CFG3_IDX), rb(ipc_pkg::VID_CODE_IDX),
                             rb(ipc_pkg::VID_CFG2_IDX), rb(ipc_pkg::VID_CFG1_IDX),
                             rb(ipc_pkg::VID_CFG0_IDX)};
        audio_frame_body <= {8'h00, rb(ipc_pkg::AUD_CFG3_IDX), rb(ipc_pkg::AUD_CFG2_IDX),
                             rb(ipc_pkg::AUD_CFG1_IDX), rb(ipc_pkg::AUD_CFG0_IDX)};
        vendor_regid <= {rb(ipc_pkg::REGID2_IDX), rb(ipc_pkg::REGID1_IDX),
                         rb(ipc_pkg::REGID0_IDX)};
        vendor_len <= vlen_reg[4:0];
        for (int i = 0; i < ipc_pkg::VPAY_LEN; i++) begin
          vendor_payload[8*i +: 8] <= regs[7'(ipc_pkg::VPAY_IDX - ipc_pkg::FIRST_IDX) + 7'(i)];
        end
        for (int i = 0; i < ipc_pkg::SPD_VEND_LEN; i++) begin
          spd_body[8*i +: 8] <= regs[7'(ipc_pkg::SPD_VEND_IDX - ipc_pkg::FIRST_IDX) + 7'(i)];
        end
        for (int i = 0; i < ipc_pkg::SPD_NAME_LEN; i++) begin
          spd_body[8*(i+8) +: 8] <= regs[7'(ipc_pkg::SPD_NAME_IDX - ipc_pkg::FIRST_IDX) + 7'(i)];
        end
        spd_body[8*24 +: 8] <= rb(ipc_pkg::SPD_INFO_IDX);
        aud_sample_flat <= auds_reg[7:4];
        // Multistream mode owns the layout, so the bit is forced to layout 0
        aud_layout <= multistream_audio_enable ? 1'b0 :
                      auds_reg[ipc_pkg::AUDS_LAYOUT_BIT];
      end
    end
  end

  // ==========================================================
  // Sample-present status of the last sample packet sent
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      present_status <= 4'h0;
      flat_q <= 4'h0;
    end else begin
      flat_q <= aud_sample_flat;
      if (aud_pkt_sent) present_status <= aud_pkt_present;
    end
  end

  // ==========================================================
  // Checks
  mute_once_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == IPC_WINDOW && gcp_sent) |=> (state == IPC_IDLE))
    else $error("mute packet not retired after send");
  mute_window_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    gcp_mute_req |-> (pix_cnt <= PIX_CNT_W'(ipc_pkg::MUTE_WINDOW_PIX)))
    else $error("mute request outside window");
  clear_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (gcp_clear_flag == $past(gcp_reg[0])))
    else $error("clear flag not from bit 0");
  filler_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl_period |=> (chan2_filler_bits == $past(regs[0][5:0])))
    else $error("filler value wrong");
  vlen_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (vendor_len == $past(regs[20][4:0])))
    else $error("vendor length wrong");
  layout_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pkt_assemble && multistream_audio_enable) |=> !aud_layout)
    else $error("layout not ignored in multistream");
  status_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    aud_pkt_sent |=> (present_status == $past(aud_pkt_present)))
    else $error("status not updated");
  regid_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (vendor_regid[23:16] == $past(regs[19])))
    else $error("regid byte 2 misplaced");
  flat_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> ##1 (flat_q == $past(auds_reg[7:4], 2)))
    else $error("sample flat wrong");

  // Field placement of every packet, judged one cycle after assembly; reserved nibble and pad byte checked on every cycle
  vid_byte0_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (video_frame_body[7:0] == $past(rb(ipc_pkg::VID_CFG0_IDX))))
    else $error("video byte 0 wrong");

  vid_byte1_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (video_frame_body[15:8] == $past(rb(ipc_pkg::VID_CFG1_IDX))))
    else $error("video byte 1 wrong");

  vid_byte2_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (video_frame_body[23:16] == $past(rb(ipc_pkg::VID_CFG2_IDX))))
    else $error("video byte 2 wrong");

  vid_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (video_frame_body[31:24] == $past(rb(ipc_pkg::VID_CODE_IDX))))
    else $error("video format id wrong");

  vid_byte3_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (video_frame_body[39:32] == $past(rb(ipc_pkg::VID_CFG3_IDX))))
    else $error("video byte 3 wrong");

  // Reserved top nibble of byte 3 must never leak into the frame
  vid_resv_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    video_frame_body[39:36] == 4'h0)
    else $error("video byte 3 reserved bits set");

  top_bar_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (video_frame_body[55:40] ==
      {$past(rb(ipc_pkg::TOP_BAR_IDX + 16'h1)), $past(rb(ipc_pkg::TOP_BAR_IDX))}))
    else $error("top bar wrong");

  right_bar_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (video_frame_body[103:88] ==
      {$past(rb(ipc_pkg::RIGHT_BAR_IDX + 16'h1)), $past(rb(ipc_pkg::RIGHT_BAR_IDX))}))
    else $error("right bar wrong");

  aud_byte0_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (audio_frame_body[7:0] == $past(rb(ipc_pkg::AUD_CFG0_IDX))))
    else $error("audio byte 0 wrong");

  aud_byte1_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (audio_frame_body[15:8] == $past(rb(ipc_pkg::AUD_CFG1_IDX))))
    else $error("audio byte 1 wrong");

  aud_alloc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (audio_frame_body[23:16] == $past(rb(ipc_pkg::AUD_CFG2_IDX))))
    else $error("speaker placement wrong");

  aud_byte3_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (audio_frame_body[31:24] == $past(rb(ipc_pkg::AUD_CFG3_IDX))))
    else $error("audio byte 3 wrong");

  aud_pad_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    audio_frame_body[39:32] == 8'h00)
    else $error("audio pad byte not zero");

  regid_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (vendor_regid[7:0] == $past(rb(ipc_pkg::REGID0_IDX))))
    else $error("regid byte 0 misplaced");

  pay_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (vendor_payload[7:0] == $past(rb(ipc_pkg::VPAY_IDX))))
    else $error("payload byte 0 wrong");

  pay_last_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (vendor_payload[191:184] == $past(rb(ipc_pkg::VPAY_IDX + 16'h17))))
    else $error("payload byte 23 wrong");

  spd_vend_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (spd_body[7:0] == $past(rb(ipc_pkg::SPD_VEND_IDX))))
    else $error("vendor name byte 0 wrong");

  spd_name_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (spd_body[71:64] == $past(rb(ipc_pkg::SPD_NAME_IDX))))
    else $error("product name byte 0 wrong");

  // Contents only move at assembly, so a write mid-packet cannot tear it
  pay_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pkt_assemble |=> $stable(vendor_payload))
    else $error("payload changed outside assembly");

  mute_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pkt_assemble |=> (gcp_mute_flag == $past(gcp_reg[ipc_pkg::GCP_SET_BIT])))
    else $error("mute flag not from set bit");

  req_state_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    gcp_mute_req |-> (state == IPC_WINDOW))
    else $error("mute request outside window state");

  filler_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ctrl_period |=> (chan2_filler_bits == 6'h00))
    else $error("filler driven outside control period");

  status_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !aud_pkt_sent |=> $stable(present_status))
    else $error("status changed without a sample packet");

endmodule : ipc_composer_cfg

// >>> verif/ipc_link_model.sv
// Link-side partner: vsync, packet assembly, audio packets and mute packet sending
`timescale 1ns/1ps
module ipc_link_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic gcp_mute_req,
  input wire logic [9:0] gcp_delay,
  output logic vsync_edge,
  output logic pixel_en,
  output logic pkt_assemble,
  output logic gcp_sent,
  output logic aud_pkt_sent,
  output logic [3:0] aud_pkt_present
);
  int sent_cnt = 0;
  logic [9:0] wait_cnt;
  assign pixel_en = rst_n;
  initial begin
    vsync_edge = 1'b0;
    pkt_assemble = 1'b0;
    aud_pkt_sent = 1'b0;
    aud_pkt_present = 4'h0;
  end
  // k: 0 vsync, 1 assemble, 2 audio packet
  task automatic pulse(input logic [1:0] k, input logic [3:0] prs);
    @(posedge ref_clk);
    vsync_edge <= k == 2'd0;
    pkt_assemble <= k == 2'd1;
    aud_pkt_sent <= k == 2'd2;
    aud_pkt_present <= prs;
    @(posedge ref_clk);
    vsync_edge <= 1'b0;
    pkt_assemble <= 1'b0;
    aud_pkt_sent <= 1'b0;
    // Stale data is inverted so nothing relies on it after the pulse
    aud_pkt_present <= ~prs;
  endtask : pulse
  // A slow delay lets the window close before the packet goes out
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gcp_sent <= 1'b0;
      wait_cnt <= 10'h000;
    end else begin
      gcp_sent <= 1'b0;
      wait_cnt <= 10'h000;
      if (gcp_mute_req && !gcp_sent) begin
        wait_cnt <= wait_cnt + 10'h001;
        if (wait_cnt == gcp_delay) begin
          gcp_sent <= 1'b1;
          sent_cnt <= sent_cnt + 1;
        end
      end
    end
  end
endmodule : ipc_link_model

// >>> verif/ipc_composer_cfg_tb.sv
// Self-checking bench for the packet composer configuration block
`timescale 1ns/1ps
module ipc_composer_cfg_tb;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic ctrl_period = 0, multistream_audio_enable = 0;
  logic [9:0] gcp_delay = 10'h1f4;
  logic [31:0] prdata;
  logic pready, vsync_edge, pixel_en, pkt_assemble, gcp_sent, aud_pkt_sent, gcp_mute_req;
  logic gcp_mute_flag, gcp_clear_flag, gcp_default_phase, aud_layout;
  logic [3:0] aud_pkt_present, aud_sample_flat;
  logic [5:0] chan2_filler_bits;
  logic [103:0] video_frame_body;
  logic [39:0] audio_frame_body;
  logic [23:0] vendor_regid;
  logic [4:0] vendor_len;
  logic [191:0] vendor_payload;
  logic [199:0] spd_body;
  logic [7:0] mem [0:79];
  logic [7:0] exp_q[$];
  int mismatches = 0, cmp_count = 0, seed = 65, n;
  ipc_composer_cfg dut (.*, .pslverr());
  ipc_link_model link (.*);
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic final_report;
    $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d, input logic [7:0] e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    if (!w) exp_q.push_back(e);
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Read data is judged against the oldest note left by the driver
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check(prdata, exp_q.size() > 0 ? {24'h0, exp_q.pop_front()} : 32'hffffffff);
    end
  end
  function automatic logic [7:0] rmask(input logic [15:0] a);
    case (a)
      ipc_pkg::CH2_FILLER_IDX: return 8'h3f;
      ipc_pkg::VID_CFG3_IDX: return 8'h0f;
      ipc_pkg::AUD_CFG0_IDX, ipc_pkg::AUD_CFG3_IDX: return 8'h7f;
      ipc_pkg::AUD_CFG1_IDX: return 8'h37;
      ipc_pkg::VLEN_IDX: return 8'h1f;
      ipc_pkg::AUDS_CFG_IDX: return 8'hf1;
      ipc_pkg::GCP_CFG_IDX, ipc_pkg::AUDS_STAT_IDX: return 8'h00;
      default: return (a > ipc_pkg::REGID1_IDX && a < ipc_pkg::REGID0_IDX) ? 8'h00 : 8'hff;
    endcase
  endfunction : rmask
  function automatic logic [7:0] m(input logic [15:0] a);
    return mem[a - ipc_pkg::FIRST_IDX] & rmask(a);
  endfunction : m
  task automatic settle(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : settle
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (logic [15:0] a = ipc_pkg::FIRST_IDX; a <= ipc_pkg::AUDS_STAT_IDX; a++) begin
      apb(0, a, 0, a == ipc_pkg::VLEN_IDX ? ipc_pkg::VLEN_RESET : 8'h00);
    end
    for (logic [15:0] a = ipc_pkg::FIRST_IDX; a <= ipc_pkg::AUDS_STAT_IDX; a++) begin
      mem[a - ipc_pkg::FIRST_IDX] = a == ipc_pkg::GCP_CFG_IDX ? 8'h00 : 8'($random(seed));
      if (a == ipc_pkg::AUDS_CFG_IDX) mem[a - ipc_pkg::FIRST_IDX] = 8'ha1;
      apb(1, a, mem[a - ipc_pkg::FIRST_IDX], 0);
    end
    for (logic [15:0] a = ipc_pkg::FIRST_IDX; a <= ipc_pkg::AUDS_STAT_IDX; a++) apb(0, a, 0, m(a));
    apb(1, 16'h1200, 8'h5a, 0);
    apb(0, 16'h1200, 0, 0);
    link.pulse(2'd1, 4'h0);
    settle(2);
    for (int k = 0; k < 13; k++) begin
      check(video_frame_body[8*k+:8], m(k < 3 ? ipc_pkg::VID_CFG0_IDX + k : k == 3 ?
        ipc_pkg::VID_CODE_IDX : k == 4 ? ipc_pkg::VID_CFG3_IDX : ipc_pkg::TOP_BAR_IDX + k - 5));
    end
    for (int k = 0; k < 5; k++) begin
      check(audio_frame_body[8*k+:8], k < 4 ? m(ipc_pkg::AUD_CFG0_IDX + k) : 8'h00);
    end
    check(vendor_regid, {m(ipc_pkg::REGID2_IDX), m(ipc_pkg::REGID1_IDX), m(ipc_pkg::REGID0_IDX)});
    check(vendor_len, m(ipc_pkg::VLEN_IDX));
    for (int k = 0; k < 24; k++) check(vendor_payload[8*k+:8], m(ipc_pkg::VPAY_IDX + k));
    for (int k = 0; k < 25; k++) check(spd_body[8*k+:8], m(ipc_pkg::SPD_VEND_IDX + k));
    check(aud_sample_flat, 4'ha);
    check(aud_layout, 1'b1);
    multistream_audio_enable <= 1'b1;
    link.pulse(2'd1, 4'h0);
    settle(2);
    check(aud_layout, 1'b0);
    apb(1, ipc_pkg::VLEN_IDX, 8'h07, 0);
    settle(2);
    check(vendor_len, m(ipc_pkg::VLEN_IDX));
    link.pulse(2'd1, 4'h0);
    settle(2);
    check(vendor_len, 5'h07);
    ctrl_period <= 1'b1;
    settle(2);
    check(chan2_filler_bits, m(ipc_pkg::CH2_FILLER_IDX));
    ctrl_period <= 1'b0;
    settle(2);
    check(chan2_filler_bits, 6'h00);
    // Phase bit set to match the packetizer's default phase
    apb(1, ipc_pkg::GCP_CFG_IDX, 8'h06, 0);
    for (int r = 0; r < 3; r++) begin
      if (r == 1) gcp_delay <= 10'h005;
      link.pulse(2'd0, 4'h0);
      n = 0;
      repeat (600) begin
        @(posedge ref_clk);
        if (gcp_mute_req === 1'b1) n++;
      end
      if (r == 0) check(n >= 380 && n <= 385, 1'b1);
      check(link.sent_cnt, r == 0 ? 0 : 1);
    end
    link.pulse(2'd1, 4'h0);
    settle(2);
    check({gcp_default_phase, gcp_mute_flag, gcp_clear_flag}, 3'b110);
    apb(1, ipc_pkg::GCP_CFG_IDX, 8'h01, 0);
    link.pulse(2'd1, 4'h0);
    settle(2);
    check({gcp_mute_flag, gcp_clear_flag}, 2'b01);
    link.pulse(2'd2, 4'hb);
    apb(0, ipc_pkg::AUDS_STAT_IDX, 0, 8'h0b);
    apb(1, ipc_pkg::AUDS_STAT_IDX, 8'hff, 0);
    apb(0, ipc_pkg::AUDS_STAT_IDX, 0, 8'h0b);
    settle(2);
    final_report();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end
endmodule : ipc_composer_cfg_tb
